/* File: design/counter_pwm_fm_generator.v */
// Ten-channel pulse-width and frequency square-wave generator with APB access
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/100ps
`include "pwm_fm_map.vh"

module counter_pwm_fm_generator #(
  parameter NCH   = 10,
  parameter CNT_W = 16
) (
  input  wire            pclk,
  input  wire            presetn,
  input  wire            psel,
  input  wire            penable,
  input  wire            pwrite,
  input  wire [11:0]     paddr,
  input  wire [31:0]     pwdata,
  output reg  [31:0]     prdata,
  output wire            pready,
  output wire            pslverr,
  output wire [NCH-1:0]  wave_out
);

  // Per-channel configuration and the inputs the host refreshes
  reg              run_reg;
  reg  [10:0]      cfg_reg    [0:NCH-1];
  reg  [CNT_W-1:0] period_reg [0:NCH-1];
  reg  [CNT_W-1:0] high_reg   [0:NCH-1];
  reg              arm_reg    [0:NCH-1];
  wire [4:0]       base_tick;
  wire [CNT_W-1:0] count      [0:NCH-1];
  wire [NCH-1:0]   armed;
  wire             wr_en;
  wire             rd_en;
  wire             ch_hit;
  wire [3:0]       ch_idx;
  wire [3:0]       ch_off;
  reg              addr_ok;
  integer          i;

  // Channel index and register offset inside a channel block
  function [3:0] chan_of;
    input [11:0] a;
    begin
      chan_of = a[`CH_STRIDE_LG+3:`CH_STRIDE_LG];
    end
  endfunction

  // Pick one frequency-base enable from the divider chain
  function sel_tick;
    input [2:0] code;
    input [4:0] ticks;
    begin
      case (code)
        `BASE_1MHZ:   sel_tick = ticks[0];
        `BASE_100KHZ: sel_tick = ticks[1];
        `BASE_10KHZ:  sel_tick = ticks[2];
        `BASE_1KHZ:   sel_tick = ticks[3];
        `BASE_100HZ:  sel_tick = ticks[4];
        default:      sel_tick = 1'b0;
      endcase
    end
  endfunction

  // APB decode: zero wait states, unmapped addresses answer with an error
  // Compare the full offset so high addresses never alias onto a channel
  assign ch_hit = (paddr >= `CH_BASE) &&
                  ((paddr - `CH_BASE) < (NCH << `CH_STRIDE_LG));
  assign ch_idx = chan_of(paddr - `CH_BASE);
  assign ch_off = paddr[3:0];
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en = psel && penable && pwrite && addr_ok;
  assign rd_en = psel && !penable && !pwrite;

  always @* begin
    addr_ok = (paddr == `CTRL_OFF) || (paddr == `STATUS_OFF) || ch_hit;
  end

  // Register writes; frequency-mode duty locks while running
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg <= 1'b0;
      for (i = 0; i < NCH; i = i + 1) begin
        cfg_reg[i]    <= 11'h000;
        period_reg[i] <= `PERIOD_RST;
        high_reg[i]   <= `HIGH_RST;
        arm_reg[i]    <= 1'b0;
      end
    end else if (wr_en) begin
      if (paddr == `CTRL_OFF)
        run_reg <= pwdata[`CTRL_RUN_BIT];
      else if (ch_hit) begin
        case (ch_off)
          `CH_CFG_OFF:
            if (!run_reg)
              cfg_reg[ch_idx] <= pwdata[10:0];
          // Period is the base-relative frequency, fixed in PWM mode
          `CH_PERIOD_OFF:
            if (!run_reg || cfg_reg[ch_idx][`CFG_MODE_BIT])
              period_reg[ch_idx] <= pwdata[CNT_W-1:0];
          // High time carries the duty fraction in PWM mode
          `CH_HIGH_OFF:
            if (!run_reg || !cfg_reg[ch_idx][`CFG_MODE_BIT])
              high_reg[ch_idx] <= pwdata[CNT_W-1:0];
          `CH_ARM_OFF:
            arm_reg[ch_idx] <= pwdata[0];
          default: ;
        endcase
      end
    end
  end

  // Read data registered in the setup phase for the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (rd_en) begin
      prdata <= 32'h00000000;
      if (paddr == `CTRL_OFF)
        prdata <= {31'h00000000, run_reg};
      else if (paddr == `STATUS_OFF)
        prdata <= {{(32-NCH){1'b0}}, wave_out};
      else if (ch_hit)
        case (ch_off)
          `CH_CFG_OFF:    prdata <= {21'h000000, cfg_reg[ch_idx]};
          `CH_PERIOD_OFF: prdata <= {count[ch_idx], period_reg[ch_idx]};
          `CH_HIGH_OFF:   prdata <= {16'h0000, high_reg[ch_idx]};
          `CH_ARM_OFF:    prdata <= {30'h00000000, armed[ch_idx],
                                     arm_reg[ch_idx]};
          default:        prdata <= 32'h00000000;
        endcase
    end
  end

  // Arm only while running; gated channels also need their arm bit
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : chan
      assign armed[g] = run_reg && cfg_reg[g][`CFG_EN_BIT] &&
                        (!cfg_reg[g][`CFG_GATED_BIT] || arm_reg[g]);
      // Independent 16-bit channel
      wave_channel #(
        .CNT_W(CNT_W)
      ) u_ch (
        .pclk            (pclk),
        .presetn         (presetn),
        .tick            (sel_tick(cfg_reg[g][`CFG_BASE_MSB:`CFG_BASE_LSB],
                                   base_tick)),
        .armed           (armed[g]),
        .order_low_first (cfg_reg[g][`CFG_ORDER_BIT]),
        .idle_level      (cfg_reg[g][`CFG_IDLE_BIT]),
        .period          (period_reg[g]),
        .high_time       (high_reg[g]),
        .wave_out        (wave_out[g]),
        .count           (count[g])
      );
    end
  endgenerate

  // Shared base divider from the 1 MHz reference
  base_divider u_div (
    .pclk      (pclk),
    .presetn   (presetn),
    .base_tick (base_tick)
  );

endmodule // counter_pwm_fm_generator

/* File: design/pwm_fm_map.vh */
// Register map, field positions and timing constants of the counter generator
`ifndef PWM_FM_MAP_VH
`define PWM_FM_MAP_VH

// Register byte offsets, per-channel blocks start at CH_BASE
`define CTRL_OFF      12'h000
`define STATUS_OFF    12'h004
`define CH_BASE       12'h040
`define CH_STRIDE_LG  4
`define CH_CFG_OFF    4'h0
`define CH_PERIOD_OFF 4'h4
`define CH_HIGH_OFF   4'h8
`define CH_ARM_OFF    4'hc

// Channel configuration fields
`define CFG_EN_BIT    0
`define CFG_MODE_BIT  1
`define CFG_ORDER_BIT 2
`define CFG_IDLE_BIT  3
`define CFG_GATED_BIT 4
`define CFG_BASE_LSB  8
`define CFG_BASE_MSB  10

// Global control fields
`define CTRL_RUN_BIT  0

// Frequency base codes
`define BASE_1MHZ     3'h0
`define BASE_100KHZ   3'h1
`define BASE_10KHZ    3'h2
`define BASE_1KHZ     3'h3
`define BASE_100HZ    3'h4

// Reference rate and system clock in kHz
`define CLK_KHZ       50000
`define XTAL_KHZ      1000
`define DECADE        10

// Reset values
`define PERIOD_RST    16'h0064
`define HIGH_RST      16'h0032

`endif

/* File: design/base_divider.v */
// Decade divider making the five selectable frequency-base enables
`timescale 1ns/100ps
`include "pwm_fm_map.vh"

module base_divider #(
  parameter PRE_DIV = `CLK_KHZ / `XTAL_KHZ
) (
  input  wire       pclk,
  input  wire       presetn,
  output wire [4:0] base_tick
);

  reg  [5:0] pre_reg;
  reg  [3:0] dec_reg [0:3];
  wire       ref_tick;
  wire [3:0] wrap;
  integer    i;

  // 1 MHz reference enable derived from pclk
  assign ref_tick = (pre_reg == PRE_DIV - 1);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pre_reg <= 6'h00;
    else if (ref_tick)
      pre_reg <= 6'h00;
    else
      pre_reg <= pre_reg + 6'h01;
  end

  // Each stage counts ten ticks of the previous stage
  assign wrap[0] = ref_tick && (dec_reg[0] == `DECADE - 1);
  assign wrap[1] = wrap[0] && (dec_reg[1] == `DECADE - 1);
  assign wrap[2] = wrap[1] && (dec_reg[2] == `DECADE - 1);
  assign wrap[3] = wrap[2] && (dec_reg[3] == `DECADE - 1);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < 4; i = i + 1)
        dec_reg[i] <= 4'h0;
    end else begin
      if (ref_tick)
        dec_reg[0] <= wrap[0] ? 4'h0 : dec_reg[0] + 4'h1;
      for (i = 1; i < 4; i = i + 1)
        if (wrap[i-1])
          dec_reg[i] <= wrap[i] ? 4'h0 : dec_reg[i] + 4'h1;
    end
  end

  assign base_tick = {wrap, ref_tick};

endmodule // base_divider

/* File: design/wave_channel.v */
// One 16-bit counter channel producing the square wave
`timescale 1ns/100ps
`include "pwm_fm_map.vh"

module wave_channel #(
  parameter CNT_W = 16
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire             tick,
  input  wire             armed,
  input  wire             order_low_first,
  input  wire             idle_level,
  input  wire [CNT_W-1:0] period,
  input  wire [CNT_W-1:0] high_time,
  output reg              wave_out,
  output wire [CNT_W-1:0] count
);

  reg  [CNT_W-1:0] cnt_reg;
  reg  [CNT_W-1:0] per_reg;
  reg  [CNT_W-1:0] hi_reg;
  wire             last;
  wire [CNT_W-1:0] low_time;
  wire             in_high;

  // Settings reload at period end or while disarmed, so a period is never torn
  assign last = (cnt_reg >= per_reg - 1'b1) || (per_reg == {CNT_W{1'b0}});
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= {CNT_W{1'b0}};
      per_reg <= `PERIOD_RST;
      hi_reg  <= `HIGH_RST;
    end else if (!armed) begin
      cnt_reg <= {CNT_W{1'b0}};
      per_reg <= period;
      hi_reg  <= high_time;
    end else if (tick) begin
      if (last) begin
        cnt_reg <= {CNT_W{1'b0}};
        per_reg <= period;
        hi_reg  <= high_time;
      end else
        cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // High phase length comes from high time, capped at the period
  assign low_time = (hi_reg >= per_reg) ? {CNT_W{1'b0}} : per_reg - hi_reg;
  assign in_high = order_low_first ? (cnt_reg >= low_time)
                                   : (cnt_reg < hi_reg);

  // Registered output; zero or full high time gives a flat line
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      wave_out <= 1'b0;
    else if (!armed)
      wave_out <= idle_level;
    else if (hi_reg == {CNT_W{1'b0}})
      wave_out <= 1'b0;
    else if (hi_reg >= per_reg)
      wave_out <= 1'b1;
    else
      wave_out <= in_high;
  end

  assign count = cnt_reg;

endmodule // wave_channel

/* File: tb/counter_pwm_fm_generator_chk.sv */
// Bus and idle-level checker for the square-wave generator
`timescale 1ns/100ps
`include "pwm_fm_map.vh"
module counter_pwm_fm_generator_chk #(
  parameter NCH = 10
) (
  input wire           pclk,
  input wire           presetn,
  input wire           psel,
  input wire           penable,
  input wire           pwrite,
  input wire [11:0]    paddr,
  input wire [31:0]    pwdata,
  input wire [31:0]    prdata,
  input wire           pready,
  input wire           pslverr,
  input wire [NCH-1:0] wave_out
);
  wire           acc = psel && penable;
  wire           wr  = acc && pwrite && !pslverr;
  wire [11:0]    ofs = paddr - `CH_BASE;
  reg            run_q;
  reg  [NCH-1:0] idle_q;

  // Shadow of run and idle bits; config writes count only while stopped
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q  <= 1'b0;
      idle_q <= {NCH{1'b0}};
    end else begin
      if (wr && paddr == `CTRL_OFF)
        run_q <= pwdata[0];
      if (wr && !run_q && paddr >= `CH_BASE && ofs[3:0] == 4'h0 &&
          ofs[11:4] < NCH)
        idle_q[ofs[11:4]] <= pwdata[3];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_PREADY_ZERO_WAIT: assert property (acc |-> pready)
    else $error("pready low in access phase");
  AST_SLVERR_UNMAPPED: assert property (
    acc && paddr >= `CH_BASE + (NCH << 4) |-> pslverr)
    else $error("no error on unmapped access");
  AST_SLVERR_CTRL_OK: assert property (
    acc && paddr == `CTRL_OFF |-> !pslverr)
    else $error("error on control access");
  AST_SLVERR_ONLY_ACCESS: assert property (!acc |-> !pslverr)
    else $error("error outside access phase");
  AST_CTRL_READBACK: assert property (
    acc && !pwrite && paddr == `CTRL_OFF |-> prdata[0] == run_q)
    else $error("run bit readback wrong");
  AST_STATUS_MIRROR: assert property (
    acc && !pwrite && paddr == `STATUS_OFF |->
    prdata[NCH-1:0] == $past(wave_out))
    else $error("status does not mirror outputs");
  AST_PRDATA_HOLD: assert property (
    !(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data changed without read");
  AST_IDLE_WHEN_STOPPED: assert property (
    !$past(run_q) && !$past(run_q, 2) && idle_q == $past(idle_q, 2)
    |-> wave_out == idle_q)
    else $error("stopped output not at idle level");

  cover property ($rose(run_q));
  cover property (acc && pslverr);
  cover property (acc && !pwrite && paddr == `STATUS_OFF);
endmodule // counter_pwm_fm_generator_chk

bind counter_pwm_fm_generator counter_pwm_fm_generator_chk #(.NCH(NCH)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .wave_out(wave_out));

/* File: tb/apb_host.sv */
// Host model driving register transfers into the generator
`timescale 1ns/100ps
module apb_host (
  input  wire        pclk,
  output reg         psel,
  output reg         penable,
  output reg         pwrite,
  output reg  [11:0] paddr,
  output reg  [31:0] pwdata,
  input  wire [31:0] prdata,
  input  wire        pready,
  input  wire        pslverr
);
  reg [31:0] rdata;
  reg        err;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end

  // One transfer; the request stays put until pready is seen high
  task xfer(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
endmodule // apb_host

/* File: tb/counter_pwm_fm_generator_tb_top.sv */
// Self-checking bench for the ten-channel square-wave generator
`timescale 1ns/100ps
`include "pwm_fm_map.vh"
module counter_pwm_fm_generator_tb_top;
  localparam WIN = 2000;
  reg         pclk, presetn;
  wire        psel, penable, pwrite, pready, pslverr;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  wire [9:0]  wave_out;
  reg  [15:0] cfg [0:9], per [0:9], hgh [0:9];
  reg  [9:0]  arm_v;
  integer     failures, samples_checked, seed, c, n, hi [0:9];

  counter_pwm_fm_generator #(.NCH(10), .CNT_W(16)) DUT (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wave_out(wave_out));
  apb_host u_host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task check(input string nm, input [31:0] exp, input [31:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask

  function [11:0] ca(input integer ch, input [3:0] o);
    ca = `CH_BASE + ch * 16 + o;
  endfunction

  // High cycles per window; the base rate cancels, so spacing is left to period_chk
  function integer exp_hi(input integer ch);
    integer h;
    begin
      h = (hgh[ch] >= per[ch]) ? per[ch] : hgh[ch];
      if (cfg[ch][0] && (!cfg[ch][4] || arm_v[ch]))
        exp_hi = h * (WIN / per[ch]);
      else
        exp_hi = cfg[ch][3] * WIN;
    end
  endfunction

  task measure;
    integer k;
    begin
      for (k = 0; k < 10; k = k + 1) hi[k] = 0;
      repeat (WIN) begin
        @(negedge pclk);
        for (k = 0; k < 10; k = k + 1) hi[k] = hi[k] + wave_out[k];
      end
      for (k = 0; k < 10; k = k + 1)
        check("high_cycles", exp_hi(k), hi[k]);
    end
  endtask

  // Rise-to-rise spacing of one channel in clock cycles
  task period_chk(input integer ch, input integer exp);
    begin
      n = 0;
      @(negedge pclk);
      while (wave_out[ch] !== 1'b0) @(negedge pclk);
      while (wave_out[ch] !== 1'b1) @(negedge pclk);
      while (wave_out[ch] !== 1'b0) begin @(negedge pclk); n = n + 1; end
      while (wave_out[ch] !== 1'b1) begin @(negedge pclk); n = n + 1; end
      check("period", exp, n);
    end
  endtask

  task test_done;
    begin
      if (failures == 0 && samples_checked > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  initial begin
    failures = 0; samples_checked = 0; seed = 14; arm_v = 10'h0;
    presetn = 1'b0;
    for (c = 0; c < 10; c = c + 1) begin
      cfg[c] = 16'h0; per[c] = `PERIOD_RST; hgh[c] = `HIGH_RST;
    end
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    u_host.xfer(1'b0, ca(0, `CH_PERIOD_OFF), 32'h0);
    check("period_rst", `PERIOD_RST, u_host.rdata[15:0]);
    u_host.xfer(1'b0, 12'hffc, 32'h0);
    check("unmapped_err", 32'h1, {31'h0, u_host.err});
    // An address 0x100 above channel 0's block must not alias onto it
    u_host.xfer(1'b0, 12'h140, 32'h0);
    check("alias_err", 32'h1, {31'h0, u_host.err});
    // Order, idle level, gate, flat duties and frequency mode, one each
    cfg[0] = 16'h001; per[0] = 16'h4; hgh[0] = 1 + {$random(seed)} % 3;
    cfg[1] = 16'h00d; per[1] = 16'h4; hgh[1] = 1 + {$random(seed)} % 3;
    cfg[2] = 16'h119; per[2] = 16'h2; hgh[2] = 16'h1;
    cfg[3] = 16'h001; per[3] = 16'h4; hgh[3] = 16'h0;
    cfg[4] = 16'h001; per[4] = 16'h4; hgh[4] = 16'h5;
    cfg[5] = 16'h003; per[5] = 16'h4; hgh[5] = 16'h1;
    for (c = 0; c < 6; c = c + 1) begin
      u_host.xfer(1'b1, ca(c, `CH_CFG_OFF), {16'h0, cfg[c]});
      u_host.xfer(1'b1, ca(c, `CH_PERIOD_OFF), {16'h0, per[c]});
      u_host.xfer(1'b1, ca(c, `CH_HIGH_OFF), {16'h0, hgh[c]});
    end
    repeat (3) @(negedge pclk);
    check("idle_level", 32'h006, {22'h0, wave_out});
    u_host.xfer(1'b1, `CTRL_OFF, 32'h1);
    repeat (3) @(negedge pclk);
    check("first_phase_hl", 32'h1, {31'h0, wave_out[0]});
    check("first_phase_lh", 32'h0, {31'h0, wave_out[1]});
    repeat (200) @(negedge pclk);
    measure;
    period_chk(0, 200);
    // Refused writes while running, then legal live updates
    u_host.xfer(1'b1, ca(0, `CH_CFG_OFF), 32'h0);
    u_host.xfer(1'b1, ca(0, `CH_PERIOD_OFF), 32'h8);
    u_host.xfer(1'b1, ca(5, `CH_HIGH_OFF), 32'h3);
    hgh[0] = 1 + {$random(seed)} % 3;
    u_host.xfer(1'b1, ca(0, `CH_HIGH_OFF), {16'h0, hgh[0]});
    per[5] = 16'h2;
    u_host.xfer(1'b1, ca(5, `CH_PERIOD_OFF), 32'h2);
    n = 75; // Host arm level in percent; half or more arms
    arm_v[2] = (n >= 50);
    u_host.xfer(1'b1, ca(2, `CH_ARM_OFF), {31'h0, arm_v[2]});
    u_host.xfer(1'b0, ca(2, `CH_ARM_OFF), 32'h0);
    check("arm_state", 32'h3, u_host.rdata);
    u_host.xfer(1'b0, ca(0, `CH_CFG_OFF), 32'h0);
    check("cfg_locked", 32'h001, u_host.rdata[15:0]);
    u_host.xfer(1'b0, ca(5, `CH_HIGH_OFF), 32'h0);
    check("fm_high_locked", 32'h1, u_host.rdata[15:0]);
    u_host.xfer(1'b0, `STATUS_OFF, 32'h0);
    repeat (1100) @(negedge pclk);
    measure;
    period_chk(2, 1000);
    period_chk(5, 100);
    period_chk(0, 200);
    u_host.xfer(1'b1, `CTRL_OFF, 32'h0);
    repeat (3) @(negedge pclk);
    check("stopped_idle", 32'h006, {22'h0, wave_out});
    test_done;
  end

  // Watchdog well past the roughly 8000 cycles the sequence needs
  initial begin
    #400000;
    failures = failures + 1;
    test_done;
  end
endmodule // counter_pwm_fm_generator_tb_top
